// ==== bie_pkg.sv ====
// Constants, types and encodings for the block input and branch execute slice
// ==========================================================================
// How it works
// - I/O address is page, count, port
// - Step input stores, advances pointer, decrements count
// - Step input: zero from count, subtract set
// - Inhibit bit traps every input here
// - Decode step byte and word input
// - Repeat transfers until count reaches zero
// - Count zero at start gives 256 transfers
// - Interrupt between transfers resumes at start
// - Decode repeat forms; finish sets zero, subtract
// - Word port input loads pointer pair, flags kept
// - Narrow bus leaves pointer low byte undefined
// - Branch on alternate accumulator/flag set, short reach
// - Branch on alternate register bank in use
// - Absolute branch condition field eight tests
// - Long relative adds 16-bit displacement to next
// - Decode direct, unconditional and register-indirect branches
// - Long relative forms and eight single-flag tests
// - Short relative: 8-bit displacement, its encodings
// - Short relative tests only zero or carry
// - Failed branch falls through; flags never change
package bie_pkg;

    // ==========================================================
    // Flag bit positions
    localparam int unsigned FLAG_S = 7;
    localparam int unsigned FLAG_Z = 6;
    localparam int unsigned FLAG_H = 4;
    localparam int unsigned FLAG_V = 2;
    localparam int unsigned FLAG_N = 1;
    localparam int unsigned FLAG_C = 0;

    // ==========================================================
    // Prefix and opcode bytes
    localparam logic [7:0] PFX_NONE    = 8'h00;
    localparam logic [7:0] PFX_ED      = 8'hED;
    localparam logic [7:0] PFX_DD      = 8'hDD;
    localparam logic [7:0] PFX_FD      = 8'hFD;
    localparam logic [7:0] OP_STEP_B   = 8'hA2;
    localparam logic [7:0] OP_STEP_W   = 8'h82;
    localparam logic [7:0] OP_REP_B    = 8'hB2;
    localparam logic [7:0] OP_REP_W    = 8'h92;
    localparam logic [7:0] OP_PAIR_IN  = 8'hB7;
    localparam logic [7:0] OP_ALT_AF   = 8'h28;
    localparam logic [7:0] OP_ALT_BANK = 8'h20;
    localparam logic [7:0] OP_JP_CC    = 8'hC2;
    localparam logic [7:0] OP_JP_MASK  = 8'hC7;
    localparam logic [7:0] OP_JP_ALW   = 8'hC3;
    localparam logic [7:0] OP_JP_IND   = 8'hE9;
    localparam logic [7:0] OP_JR_CC    = 8'h20;
    localparam logic [7:0] OP_JR_MASK  = 8'hE7;
    localparam logic [7:0] OP_JR_ALW   = 8'h18;

    // Instruction lengths in bytes
    localparam logic [15:0] LEN_ONE   = 16'h0001;
    localparam logic [15:0] LEN_TWO   = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;
    localparam logic [15:0] LEN_FOUR  = 16'h0004;

    // ==========================================================
    // Register map (byte addresses) and control bits
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_PAGE      = 8'h04;
    localparam logic [7:0]  REG_STATUS    = 8'h08;
    localparam int unsigned CTRL_INHIBIT  = 0;
    localparam int unsigned CTRL_ALT_AF   = 1;
    localparam int unsigned CTRL_ALT_BANK = 2;
    localparam int unsigned CTRL_BUS8     = 3;
    localparam logic [3:0]  CTRL_RST      = 4'h0;
    localparam logic [7:0]  PAGE_RST      = 8'h00;
    localparam logic [7:0]  UNDEF_BYTE    = 8'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_IO, ST_MEM} bie_state_e;
    typedef enum logic [1:0] {K_STEP, K_REP, K_PAIR} bie_kind_e;

    typedef struct packed {
        logic [7:0]  prefix;
        logic [7:0]  opcode;
        logic [15:0] operand;
        logic [15:0] pc;
        logic [15:0] xy;
        logic [7:0]  b;
        logic [7:0]  c;
        logic [15:0] hl;
        logic [7:0]  flags;
    } bie_instr_s;

    typedef struct packed {
        logic [15:0] pc;
        logic        pc_load;
        logic [7:0]  b;
        logic [15:0] hl;
        logic [7:0]  flags;
        logic        trap;
        logic        int_break;
        logic        unknown;
    } bie_result_s;

endpackage : bie_pkg

// ==== bie_exec.sv ====
// Decode and execute unit for block input and conditional branches
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module bie_exec (
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // Instruction from the datapath
    input  wire logic             instr_valid,
    input  wire bie_pkg::bie_instr_s instr,
    output logic                  instr_ready,
    input  wire logic             int_req,
    // Result to the datapath
    output logic                  done,
    output bie_pkg::bie_result_s  result,
    // I/O read port
    output logic                  io_req,
    output logic [23:0]           io_addr,
    output logic                  io_word,
    input  wire logic             io_ack,
    input  wire logic [15:0]      io_rdata,
    // Memory write port
    output logic                  mem_req,
    output logic [15:0]           mem_addr,
    output logic [15:0]           mem_wdata,
    output logic                  mem_word,
    input  wire logic             mem_ack
);

    // ==========================================================
    // Bus slave
    logic [3:0]  ctrl_q;
    logic [7:0]  page_q;
    logic        dph_wr_q;
    logic        dph_rd_q;
    logic [7:0]  dph_addr_q;
    logic [31:0] status_w;

    wire ahb_take = hsel && htrans[1] && hready && ce;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dph_wr_q   <= 1'b0;
            dph_rd_q   <= 1'b0;
            dph_addr_q <= 8'h00;
        end else if (ce) begin
            dph_wr_q   <= ahb_take && hwrite;
            dph_rd_q   <= ahb_take && !hwrite;
            dph_addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= bie_pkg::CTRL_RST;
            page_q <= bie_pkg::PAGE_RST;
        end else if (ce && dph_wr_q) begin
            if (dph_addr_q == bie_pkg::REG_CTRL)
                ctrl_q <= hwdata[3:0];
            if (dph_addr_q == bie_pkg::REG_PAGE)
                page_q <= hwdata[7:0];
        end
    end

    // Stall the bus while the block is frozen
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    wire sel_ctrl   = dph_rd_q && dph_addr_q == bie_pkg::REG_CTRL;
    wire sel_page   = dph_rd_q && dph_addr_q == bie_pkg::REG_PAGE;
    wire sel_status = dph_rd_q && dph_addr_q == bie_pkg::REG_STATUS;
    assign hrdata = sel_ctrl   ? {28'h000_0000, ctrl_q} :
                    sel_page   ? {24'h00_0000, page_q} :
                    sel_status ? status_w : 32'h0000_0000;

    wire inhibit  = ctrl_q[bie_pkg::CTRL_INHIBIT];
    wire alt_af   = ctrl_q[bie_pkg::CTRL_ALT_AF];
    wire alt_bank = ctrl_q[bie_pkg::CTRL_ALT_BANK];
    wire bus8     = ctrl_q[bie_pkg::CTRL_BUS8];

    // ==========================================================
    // Decode
    wire [7:0] op     = instr.opcode;
    wire [2:0] cc     = op[5:3];
    wire [7:0] fl     = instr.flags;
    wire       pf_no  = instr.prefix == bie_pkg::PFX_NONE;
    wire       pf_ed  = instr.prefix == bie_pkg::PFX_ED;
    wire       pf_dd  = instr.prefix == bie_pkg::PFX_DD;
    wire       pf_fd  = instr.prefix == bie_pkg::PFX_FD;

    wire d_step_b = pf_ed && op == bie_pkg::OP_STEP_B;
    wire d_step_w = pf_ed && op == bie_pkg::OP_STEP_W;
    wire d_rep_b  = pf_ed && op == bie_pkg::OP_REP_B;
    wire d_rep_w  = pf_ed && op == bie_pkg::OP_REP_W;
    wire d_pair   = pf_ed && op == bie_pkg::OP_PAIR_IN;
    wire d_io     = d_step_b || d_step_w || d_rep_b || d_rep_w || d_pair;
    wire d_word   = d_step_w || d_rep_w || d_pair;

    wire d_alt_af   = pf_dd && op == bie_pkg::OP_ALT_AF;
    wire d_alt_bank = pf_dd && op == bie_pkg::OP_ALT_BANK;
    wire jp_cc_op   = (op & bie_pkg::OP_JP_MASK) == bie_pkg::OP_JP_CC;
    wire d_jp_da_cc = pf_no && jp_cc_op;
    wire d_jp_da    = pf_no && op == bie_pkg::OP_JP_ALW;
    wire d_jp_hl    = pf_no && op == bie_pkg::OP_JP_IND;
    wire d_jp_ir_cc = pf_dd && jp_cc_op;
    wire d_jp_xy    = (pf_dd || pf_fd) && op == bie_pkg::OP_JP_IND;
    wire d_jp_ra_cc = pf_fd && jp_cc_op;
    wire d_jp_ra    = pf_fd && op == bie_pkg::OP_JP_ALW;
    wire d_jr_cc    = pf_no && (op & bie_pkg::OP_JR_MASK) == bie_pkg::OP_JR_CC;
    wire d_jr       = pf_no && op == bie_pkg::OP_JR_ALW;
    wire d_branch   = d_alt_af || d_alt_bank || d_jp_da_cc || d_jp_da || d_jp_hl || d_jp_ir_cc
                      || d_jp_xy || d_jp_ra_cc || d_jp_ra || d_jr_cc || d_jr;

    // Eight-way flag test; the short form reuses its first four codes
    function automatic logic cc_test(input logic [2:0] sel, input logic [7:0] f);
        case (sel)
            3'd0:    cc_test = !f[bie_pkg::FLAG_Z];
            3'd1:    cc_test = f[bie_pkg::FLAG_Z];
            3'd2:    cc_test = !f[bie_pkg::FLAG_C];
            3'd3:    cc_test = f[bie_pkg::FLAG_C];
            3'd4:    cc_test = !f[bie_pkg::FLAG_V];
            3'd5:    cc_test = f[bie_pkg::FLAG_V];
            3'd6:    cc_test = !f[bie_pkg::FLAG_S];
            default: cc_test = f[bie_pkg::FLAG_S];
        endcase
    endfunction : cc_test

    wire cc_long  = cc_test(cc, fl);
    wire cc_short = cc_test({1'b0, cc[1:0]}, fl);

    wire taken = (d_alt_af && alt_af) || (d_alt_bank && alt_bank)
                 || ((d_jp_da_cc || d_jp_ir_cc || d_jp_ra_cc) && cc_long)
                 || (d_jr_cc && cc_short)
                 || d_jp_da || d_jp_hl || d_jp_xy || d_jp_ra || d_jr;

    wire [15:0] br_len = (d_jp_hl)                        ? bie_pkg::LEN_ONE :
                         (d_jr || d_jr_cc || d_jp_ir_cc || d_jp_xy) ? bie_pkg::LEN_TWO :
                         (d_jp_ra || d_jp_ra_cc)          ? bie_pkg::LEN_FOUR :
                                                            bie_pkg::LEN_THREE;
    wire [15:0] next_pc = instr.pc + br_len;
    wire [15:0] disp8   = {{8{instr.operand[7]}}, instr.operand[7:0]};
    wire [15:0] rel8    = next_pc + disp8;
    wire [15:0] rel16   = next_pc + instr.operand;
    wire [15:0] target  = (d_jp_da || d_jp_da_cc)    ? instr.operand :
                          (d_jp_hl || d_jp_ir_cc)    ? instr.hl :
                          d_jp_xy                    ? instr.xy :
                          (d_jp_ra || d_jp_ra_cc)    ? rel16 : rel8;

    // ==========================================================
    // Execute
    bie_pkg::bie_state_e  state_q;
    bie_pkg::bie_kind_e   kind_q;
    logic                 word_q;
    logic [7:0]           b_q;
    logic [7:0]           c_q;
    logic [15:0]          hl_q;
    logic [7:0]           flags_q;
    logic [15:0]          pc_q;
    logic [15:0]          data_q;
    logic                 done_q;
    bie_pkg::bie_result_s res_q;

    assign instr_ready = ce && state_q == bie_pkg::ST_IDLE;
    wire   accept      = instr_valid && instr_ready;
    wire   io_fin      = ce && state_q == bie_pkg::ST_IO && io_ack;
    wire   mem_fin     = ce && state_q == bie_pkg::ST_MEM && mem_ack;

    wire [7:0]  b_dec   = b_q - 8'h01;
    wire [15:0] hl_step = hl_q + (word_q ? bie_pkg::LEN_TWO : bie_pkg::LEN_ONE);
    wire        b_zero  = b_dec == 8'h00;
    // Byte wrap of the counter makes a start value of zero run 256 times
    wire        rep_end = kind_q != bie_pkg::K_REP || b_zero;
    // Zero from count; subtract set; others kept
    wire [7:0]  fl_fin  = (flags_q & ~(8'h01 << bie_pkg::FLAG_Z))
                          | ({7'h00, b_zero} << bie_pkg::FLAG_Z)
                          | (8'h01 << bie_pkg::FLAG_N);
    wire [15:0] pair_in = bus8 ? {io_rdata[7:0], bie_pkg::UNDEF_BYTE} : io_rdata;

    assign io_req    = state_q == bie_pkg::ST_IO;
    assign io_addr   = {page_q, b_q, c_q};
    assign io_word   = word_q;
    assign mem_req   = state_q == bie_pkg::ST_MEM;
    assign mem_addr  = hl_q;
    assign mem_wdata = data_q;
    assign mem_word  = word_q;
    assign done      = done_q;
    assign result    = res_q;
    assign status_w  = {20'h0_0000, b_q, word_q, kind_q, state_q != bie_pkg::ST_IDLE};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= bie_pkg::ST_IDLE;
            kind_q  <= bie_pkg::K_STEP;
            word_q  <= 1'b0;
            b_q     <= 8'h00;
            c_q     <= 8'h00;
            hl_q    <= 16'h0000;
            flags_q <= 8'h00;
            pc_q    <= 16'h0000;
            data_q  <= 16'h0000;
            done_q  <= 1'b0;
            res_q   <= '0;
        end else if (ce) begin
            done_q <= 1'b0;
            case (state_q)
                bie_pkg::ST_IDLE: begin
                    if (accept && d_io && inhibit) begin
                        done_q          <= 1'b1;
                        res_q           <= '0;
                        res_q.trap      <= 1'b1;
                        res_q.pc        <= instr.pc;
                        res_q.b         <= instr.b;
                        res_q.hl        <= instr.hl;
                        res_q.flags     <= instr.flags;
                    end else if (accept && d_io) begin
                        state_q <= bie_pkg::ST_IO;
                        kind_q  <= d_pair ? bie_pkg::K_PAIR :
                                   (d_rep_b || d_rep_w) ? bie_pkg::K_REP : bie_pkg::K_STEP;
                        word_q  <= d_word;
                        b_q     <= instr.b;
                        c_q     <= instr.c;
                        hl_q    <= instr.hl;
                        flags_q <= instr.flags;
                        pc_q    <= instr.pc;
                    end else if (accept) begin
                        done_q          <= 1'b1;
                        res_q           <= '0;
                        res_q.pc        <= !d_branch ? instr.pc : (taken ? target : next_pc);
                        res_q.pc_load   <= d_branch && taken;
                        res_q.b         <= instr.b;
                        res_q.hl        <= instr.hl;
                        res_q.flags     <= instr.flags;
                        res_q.unknown   <= !d_branch;
                    end
                end
                bie_pkg::ST_IO: begin
                    if (io_fin && kind_q == bie_pkg::K_PAIR) begin
                        state_q         <= bie_pkg::ST_IDLE;
                        hl_q            <= pair_in;
                        done_q          <= 1'b1;
                        res_q           <= '0;
                        res_q.pc        <= pc_q;
                        res_q.b         <= b_q;
                        res_q.hl        <= pair_in;
                        res_q.flags     <= flags_q;
                    end else if (io_fin) begin
                        state_q <= bie_pkg::ST_MEM;
                        data_q  <= io_rdata;
                    end
                end
                bie_pkg::ST_MEM: begin
                    if (mem_fin) begin
                        b_q  <= b_dec;
                        hl_q <= hl_step;
                        if (rep_end || int_req) begin
                            state_q         <= bie_pkg::ST_IDLE;
                            done_q          <= 1'b1;
                            res_q           <= '0;
                            res_q.pc        <= pc_q;
                            res_q.b         <= b_dec;
                            res_q.hl        <= hl_step;
                            res_q.flags     <= rep_end ? fl_fin : flags_q;
                            res_q.int_break <= !rep_end;
                        end else begin
                            state_q <= bie_pkg::ST_IO;
                        end
                    end
                end
                default: state_q <= bie_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    sequence s_trap_take;
        instr_valid && instr_ready && d_io && inhibit;
    endsequence
    sequence s_trap_out;
        done && result.trap && !io_req;
    endsequence
    sequence s_transfer;
        mem_req && mem_ack;
    endsequence

    io_addr_map_a: assert property (io_req |-> io_addr == {page_q, b_q, c_q} && io_addr[15:8] == b_q)
        else $error("I/O address not page, count, port");
    ptr_advance_a: assert property (s_transfer |=> hl_q == $past(hl_q) + (word_q ? 16'h0002 : 16'h0001)
        && b_q == $past(b_q) - 8'h01)
        else $error("Pointer or count not advanced");
    step_flags_a: assert property (done && !result.trap && !result.int_break && $past(kind_q) == bie_pkg::K_STEP
        && $past(state_q) == bie_pkg::ST_MEM |-> result.flags[bie_pkg::FLAG_N]
        && result.flags[bie_pkg::FLAG_Z] == (result.b == 8'h00))
        else $error("Step input flags wrong");
    trap_input_a: assert property (s_trap_take |=> s_trap_out)
        else $error("Inhibited input did not trap");
    rep_finish_a: assert property (done && $past(kind_q) == bie_pkg::K_REP && $past(state_q) == bie_pkg::ST_MEM
        && !result.int_break |-> result.b == 8'h00 && result.flags[bie_pkg::FLAG_Z] && result.flags[bie_pkg::FLAG_N])
        else $error("Repeat input ended early or flags wrong");
    rep_continue_a: assert property (s_transfer and (kind_q == bie_pkg::K_REP && b_q != 8'h01 && !int_req)
        |=> io_req)
        else $error("Repeat input stopped before zero");
    int_resume_a: assert property (done && result.int_break |-> result.pc == $past(pc_q) && result.b != 8'h00)
        else $error("Interrupted repeat does not resume at start");
    branch_flags_a: assert property (instr_valid && instr_ready && d_branch |=> done && !result.trap
        && result.flags == $past(instr.flags) && (result.pc_load || result.pc == $past(next_pc)))
        else $error("Branch changed flags or skipped fall-through");
    jr_target_a: assert property (instr_valid && instr_ready && d_jr |=> result.pc_load
        && result.pc == $past(instr.pc) + 16'h0002 + {{8{$past(instr.operand[7])}}, $past(instr.operand[7:0])})
        else $error("Short relative target wrong");

endmodule : bie_exec
`default_nettype wire

// ==== bie_far.sv ====
// I/O peripheral and memory model for the block input unit
`timescale 1ns/100ps
`default_nettype none
module bie_far (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // I/O read port
    input  wire logic        io_req,
    input  wire logic [23:0] io_addr,
    output logic             io_ack,
    output logic [15:0]      io_rdata,
    // Memory write port
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_word,
    output logic             mem_ack
);
    logic [7:0]  mem [logic [15:0]];
    logic [23:0] alog [$];
    logic        qi, qm, qw, sl;
    logic [15:0] qa, qd;
    logic [23:0] qp;
    int          w;
    // ========================
    // Port data follows its address so the bench can predict it
    function automatic logic [15:0] pdat(input logic [23:0] a);
        return {~a[15:8], a[23:16] ^ a[15:8] ^ a[7:0]};
    endfunction : pdat
    // Mid-cycle snapshot keeps the edge logic clear of design flop races
    always @(negedge clk) begin
        {qi, qm, qw, qa, qd, qp} <= {io_req, mem_req, mem_word, mem_addr, mem_wdata, io_addr};
    end
    // ========================
    // I/O answers alternate prompt and slow, memory answers promptly; an idle data bus toggles
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            io_ack   <= 1'b0;
            mem_ack  <= 1'b0;
            io_rdata <= 16'hA5A5;
            sl       <= 1'b0;
            w        <= 0;
        end else begin
            io_ack   <= 1'b0;
            mem_ack  <= 1'b0;
            io_rdata <= ~io_rdata;
            if (mem_ack) begin
                mem[qa] = qd[7:0];
                if (qw) mem[qa + 16'h0001] = qd[15:8];
            end
            if (qm && !mem_ack) mem_ack <= 1'b1;
            if (qi && !io_ack) begin
                w <= w + 1;
                if (w >= (sl ? 3 : 0)) begin
                    io_ack   <= 1'b1;
                    io_rdata <= pdat(qp);
                    alog.push_back(qp);
                    w        <= 0;
                    sl       <= !sl;
                end
            end
        end
    end
endmodule : bie_far
`default_nettype wire

// ==== bie_tb.sv ====
// Self-checking bench for block input and branch execution
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic                      ce = 1'b0;
    logic                      hsel = 1'b0;
    logic                      hwrite = 1'b0;
    logic [1:0]                htrans = 2'h0;
    logic [31:0]               haddr = 32'h0000_0000;
    logic [31:0]               hwdata = 32'h0000_0000, rd;
    logic                      instr_valid = 1'b0;
    logic                      int_req = 1'b0;
    bie_pkg::bie_instr_s       instr = '0;
    wire logic                 hreadyout, hresp, instr_ready, done, io_req, io_ack, mem_req, mem_word, mem_ack;
    wire logic [31:0]          hrdata;
    wire logic [23:0]          io_addr;
    wire logic [15:0]          io_rdata, mem_addr, mem_wdata;
    wire bie_pkg::bie_result_s result;
    int                        num_errors = 0;
    int                        samples_checked = 0;
    logic [7:0]                ops [5] = '{8'hA2, 8'h82, 8'hB2, 8'h92, 8'hB7};
    always #2 clk = ~clk;
    bie_exec dut (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .int_req(int_req), .done(done),
        .result(result), .io_req(io_req), .io_addr(io_addr), .io_word(), .io_ack(io_ack), .io_rdata(io_rdata),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_word(mem_word), .mem_ack(mem_ack));
    bie_far far (.clk(clk), .rst(rst), .io_req(io_req), .io_addr(io_addr), .io_ack(io_ack), .io_rdata(io_rdata),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_word(mem_word), .mem_ack(mem_ack));
    // ========================
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // Single word transfer; entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic run(input logic [7:0] pf, op, input logic [15:0] opd, pc, hl, input logic [7:0] b, c, f);
        instr       <= '{pf, op, opd, pc, ~hl, b, c, hl, f};
        instr_valid <= 1'b1;
        do @(negedge clk); while (instr_ready !== 1'b1);
        @(posedge clk);
        instr_valid <= 1'b0;
        do @(negedge clk); while (done !== 1'b1);
        @(posedge clk);
    endtask : run
    task automatic br(input logic [7:0] pf, op, input logic [15:0] opd, pc, tgt, len, input logic [7:0] f,
                      input logic tk);
        run(pf, op, opd, pc, 16'h4321, 8'h00, 8'h00, f);
        chk("pc_load", result.pc_load, tk);
        chk("pc", result.pc, tk ? tgt : pc + len);
        chk("flags", result.flags, f);
    endtask : br
    // ========================
    initial begin
        int          k;
        logic [15:0] d;
        logic [7:0]  f;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        ce <= #12 1'b1;
        ahb(1'b1, 8'h04, 32'h0000_0033);
        ahb(1'b0, 8'hF0, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        run(8'hED, 8'hA2, 16'h0000, 16'h1000, 16'h5002, 8'h15, 8'h64, 8'hFD);
        d = far.pdat(24'h33_1564);
        chk("io_addr", far.alog[0], 24'h33_1564);
        chk("mem", far.mem[16'h5002], d[7:0]);
        chk("hl", result.hl, 16'h5003);
        chk("b", result.b, 8'h14);
        chk("flags", result.flags, 8'hBF);
        run(8'hED, 8'h82, 16'h0000, 16'h1000, 16'h6000, 8'h01, 8'h20, 8'h00);
        d = far.pdat(24'h33_0120);
        chk("mem_lo", far.mem[16'h6000], d[7:0]);
        chk("mem_hi", far.mem[16'h6001], d[15:8]);
        chk("hl", result.hl, 16'h6002);
        chk("flags", result.flags, 8'h42);
        k = far.alog.size();
        run(8'hED, 8'h92, 16'h0000, 16'h1000, 16'h4002, 8'h02, 8'h55, 8'h00);
        d = far.pdat(24'h33_0155);
        chk("count", far.alog.size() - k, 2);
        chk("io_addr", far.alog[k + 1], 24'h33_0155);
        chk("mem_hi", far.mem[16'h4005], d[15:8]);
        chk("hl", result.hl, 16'h4006);
        chk("flags", result.flags, 8'h42);
        k = far.alog.size();
        run(8'hED, 8'hB2, 16'h0000, 16'h1000, 16'h8000, 8'h00, 8'h07, 8'hFD);
        d = far.pdat(24'h33_0107);
        chk("count", far.alog.size() - k, 256);
        chk("hl", result.hl, 16'h8100);
        chk("mem", far.mem[16'h80FF], d[7:0]);
        chk("flags", result.flags, 8'hFF);
        int_req <= 1'b1;
        k = far.alog.size();
        run(8'hED, 8'hB2, 16'h0000, 16'h2222, 16'h9000, 8'h05, 8'h07, 8'h00);
        int_req <= 1'b0;
        chk("int_break", result.int_break, 1);
        chk("pc", result.pc, 16'h2222);
        chk("count", far.alog.size() - k, 1);
        run(8'hED, 8'hB7, 16'h0000, 16'h1000, 16'h3333, 8'h26, 8'h50, 8'h5A);
        d = far.pdat(24'h33_2650);
        chk("pair", result.hl, d);
        chk("flags", result.flags, 8'h5A);
        ahb(1'b1, 8'h00, 32'h0000_0008);
        run(8'hED, 8'hB7, 16'h0000, 16'h1000, 16'h3333, 8'h26, 8'h50, 8'h5A);
        chk("pair8", result.hl, {d[7:0], 8'h00});
        ahb(1'b1, 8'h00, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            k = far.alog.size();
            run(8'hED, ops[i], 16'h0000, 16'h1000, 16'h7000, 8'h03, 8'h01, 8'h00);
            chk("trap", result.trap, 1);
            chk("no_io", far.alog.size() - k, 0);
        end
        ahb(1'b1, 8'h00, 32'h0000_0000);
        br(8'hDD, 8'h28, 16'h0080, 16'h1000, 16'h0F83, 16'h0003, 8'h00, 1'b0);
        ahb(1'b1, 8'h00, 32'h0000_0002);
        br(8'hDD, 8'h28, 16'h0080, 16'h1000, 16'h0F83, 16'h0003, 8'h00, 1'b1);
        br(8'hDD, 8'h20, 16'h007F, 16'h1000, 16'h1082, 16'h0003, 8'h00, 1'b0);
        ahb(1'b1, 8'h00, 32'h0000_0004);
        br(8'hDD, 8'h20, 16'h007F, 16'h1000, 16'h1082, 16'h0003, 8'h00, 1'b1);
        ahb(1'b1, 8'h00, 32'h0000_0000);
        // Clear flags pass even codes, S Z V C set pass odd codes
        for (k = 0; k < 16; k++) begin
            f = k[3] ? 8'hC5 : 8'h00;
            br(8'h00, {2'b11, k[2:0], 3'b010}, 16'hBEEF, 16'h1000, 16'hBEEF, 16'h0003, f, k[0] == k[3]);
            br(8'hFD, {2'b11, k[2:0], 3'b010}, 16'h8000, 16'h9000, 16'h1004, 16'h0004, f, k[0] == k[3]);
            if (k[2]) br(8'h00, {2'b00, k[2:0], 3'b000}, 16'h0080, 16'h5000, 16'h4F82, 16'h0002, f, k[0] == k[3]);
        end
        br(8'h00, 8'hC3, 16'hABCD, 16'h1000, 16'hABCD, 16'h0003, 8'hC5, 1'b1);
        br(8'hFD, 8'hC3, 16'h7FFF, 16'h0100, 16'h8103, 16'h0004, 8'hC5, 1'b1);
        br(8'h00, 8'hE9, 16'h0000, 16'h1000, 16'h4321, 16'h0001, 8'h00, 1'b1);
        br(8'hDD, 8'hC2, 16'h0000, 16'h1000, 16'h4321, 16'h0002, 8'h00, 1'b1);
        br(8'hFD, 8'hE9, 16'h0000, 16'h1000, 16'hBCDE, 16'h0002, 8'h00, 1'b1);
        br(8'h00, 8'h18, 16'h007F, 16'h5000, 16'h5081, 16'h0002, 8'h00, 1'b1);
        close_out();
    end
    // Well past the longest repeat run
    initial begin
        #80000;
        num_errors++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
